// >>> cie_defs.svh
`ifndef CIE_DEFS_SVH
`define CIE_DEFS_SVH

// Special function register addresses
`define CIE_ADDR_STATUS      8'hA4
`define CIE_ADDR_SOURCE      8'hA5
`define CIE_ADDR_TX_ERR      8'hA6
`define CIE_ADDR_RX_ERR      8'hA7
`define CIE_ADDR_IRQ_ENABLE  8'hA8
`define CIE_ADDR_SLOT1_CTRL  8'hAB

// Field positions
`define CIE_IE_GLOBAL_BIT    7
`define CIE_SLOT_READY_BIT   7
`define CIE_SLOT_TXIE_BIT    6
`define CIE_SLOT_RXIE_BIT    5
`define CIE_SLOT_IRQ_BIT     4

// Reset values
`define CIE_RESET_BYTE       8'h00
`define CIE_RESET_COUNT      9'h000

// Source indicator codes
`define CIE_CODE_NONE        8'h00
`define CIE_CODE_STATUS      8'h01
`define CIE_CODE_SLOT15      8'h02
`define CIE_CODE_SLOT_BASE   8'h02
`define CIE_CODE_LAST        8'h10

// Fault confinement levels and steps
`define CIE_WARN_LIMIT       9'h060
`define CIE_PASSIVE_LIMIT    9'h080
`define CIE_BUSOFF_LIMIT     9'h0FF
`define CIE_TX_ERR_STEP      9'h008
`define CIE_COUNT_ONE        9'h001

`endif

// >>> cie_pkg.sv
package cie_pkg;

    // Control bits of the slot 1 control register
    typedef struct packed {
        logic ready;
        logic tx_irq_en;
        logic rx_irq_en;
        logic irq_flag;
    } cie_slot_ctrl_type;

    // One-cycle events from the CAN protocol engine
    typedef struct packed {
        logic tx_error;
        logic rx_error;
        logic tx_ok;
        logic rx_ok;
        logic slot1_tx_done;
        logic slot1_rx_done;
        logic status_change;
        logic error_change;
    } cie_engine_evt_type;

    // Fault confinement state, one-hot
    typedef enum logic [3:0] {
        CIE_ERR_ACTIVE  = 4'b0001,
        CIE_ERR_WARNING = 4'b0010,
        CIE_ERR_PASSIVE = 4'b0100,
        CIE_BUS_OFF     = 4'b1000
    } cie_fault_state_type;

endpackage

// >>> cie_core.sv
`timescale 1ns/1ps
`include "cie_defs.svh"
module cie_core
    import cie_pkg::*;
(
    // Clock and reset
    input  wire logic                sys_clk_i,
    input  wire logic                reset_i,
    // Special function register bus
    input  wire logic [7:0]          sfr_addr_i,
    input  wire logic                sfr_wr_i,
    input  wire logic                sfr_rd_i,
    input  wire logic [7:0]          sfr_wdata_i,
    output logic      [7:0]          sfr_rdata_o,
    // Control bits held in other registers
    input  wire logic                can_soft_reset_i,
    input  wire logic                soft_init_mode_i,
    input  wire logic                error_limit_select_i,
    input  wire logic                error_irq_enable_i,
    input  wire logic                status_irq_enable_i,
    input  wire logic                powerfail_irq_enable_i,
    input  wire logic                powerfail_req_i,
    // CAN engine side
    input  wire cie_engine_evt_type  engine_evt_i,
    input  wire logic [15:2]         slot_irq_flag_i,
    output logic                     slot1_ready_o,
    // Status and interrupt outputs
    output logic      [7:0]          irq_source_code_o,
    output logic                     can_irq_o,
    output logic                     can_irq_gated_o,
    output logic                     powerfail_irq_o,
    output logic                     error_limit_flag_o,
    output logic                     bus_off_o,
    output cie_fault_state_type      fault_state_o
);

    // Highest priority active source, 0 when none
    function automatic logic [7:0] cie_pick(input logic        st,
                                            input logic [15:1] fl);
        logic [7:0] c;
        c = `CIE_CODE_NONE;
        for (int i = 14; i >= 1; i--) begin
            if (fl[i]) begin
                c = 8'(i) + `CIE_CODE_SLOT_BASE;
            end
        end
        if (st) begin
            c = `CIE_CODE_STATUS;
        end else if (fl[15]) begin
            c = `CIE_CODE_SLOT15;
        end
        return c;
    endfunction

    // Whether the source behind a code is still active
    function automatic logic cie_live(input logic [7:0]  code,
                                      input logic        st,
                                      input logic [15:1] fl);
        logic l;
        l = (code == `CIE_CODE_STATUS) ? st : 1'b0;
        if (code == `CIE_CODE_SLOT15) begin
            l = fl[15];
        end
        for (int i = 1; i <= 14; i++) begin
            if (code == 8'(i) + `CIE_CODE_SLOT_BASE) begin
                l = fl[i];
            end
        end
        return l;
    endfunction

    logic [8:0]        tx_cnt;
    logic [7:0]        rx_cnt;
    logic [8:0]        next_tx;
    logic [7:0]        next_rx;
    logic [7:0]        irq_enable;
    logic              status_pend;
    logic [7:0]        next_code;
    logic [15:1]       all_flags;
    logic              wr_tx;
    logic              wr_tx_ok;
    logic              rd_status;
    logic              next_limit;
    logic [8:0]        limit;
    cie_slot_ctrl_type slot1;
    cie_slot_ctrl_type next_slot1;

    assign wr_tx     = sfr_wr_i && (sfr_addr_i == `CIE_ADDR_TX_ERR);
    assign wr_tx_ok  = wr_tx && soft_init_mode_i && !bus_off_o;
    assign rd_status = sfr_rd_i && (sfr_addr_i == `CIE_ADDR_STATUS);
    assign all_flags = {slot_irq_flag_i, slot1.irq_flag};

    // Status-change pending state; set beats the read that clears it
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || can_soft_reset_i) begin
            status_pend <= 1'b0;
        end else if ((engine_evt_i.status_change && status_irq_enable_i)
                  || (engine_evt_i.error_change && error_irq_enable_i)) begin
            status_pend <= 1'b1;
        end else if (rd_status) begin
            status_pend <= 1'b0;
        end
    end

    // Indicator latches a source and keeps it until that source is gone
    always_comb begin
        next_code = irq_source_code_o;
        if (irq_source_code_o == `CIE_CODE_NONE) begin
            next_code = cie_pick(status_pend, all_flags);
        end else if (!cie_live(irq_source_code_o, status_pend,
                               all_flags)) begin
            next_code = cie_pick(status_pend, all_flags);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            irq_source_code_o <= `CIE_CODE_NONE;
            can_irq_o         <= 1'b0;
            can_irq_gated_o   <= 1'b0;
        end else begin
            irq_source_code_o <= next_code;
            can_irq_o         <= (next_code != `CIE_CODE_NONE);
            can_irq_gated_o   <= (next_code != `CIE_CODE_NONE)
                                 && irq_enable[`CIE_IE_GLOBAL_BIT];
        end
    end

    // Interrupt enable register; power-fail bypasses the global mask
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            irq_enable      <= `CIE_RESET_BYTE;
            powerfail_irq_o <= 1'b0;
        end else begin
            if (sfr_wr_i && (sfr_addr_i == `CIE_ADDR_IRQ_ENABLE)) begin
                irq_enable <= sfr_wdata_i;
            end
            powerfail_irq_o <= powerfail_req_i && powerfail_irq_enable_i;
        end
    end

    // Slot 1 control; engine events are ignored while it is not ready
    always_comb begin
        next_slot1 = slot1;
        if (sfr_wr_i && (sfr_addr_i == `CIE_ADDR_SLOT1_CTRL)) begin
            next_slot1.ready     = sfr_wdata_i[`CIE_SLOT_READY_BIT];
            next_slot1.tx_irq_en = sfr_wdata_i[`CIE_SLOT_TXIE_BIT];
            next_slot1.rx_irq_en = sfr_wdata_i[`CIE_SLOT_RXIE_BIT];
            next_slot1.irq_flag  = sfr_wdata_i[`CIE_SLOT_IRQ_BIT];
        end
        if (slot1.ready && ((engine_evt_i.slot1_tx_done && slot1.tx_irq_en)
                || (engine_evt_i.slot1_rx_done && slot1.rx_irq_en))) begin
            next_slot1.irq_flag = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i || can_soft_reset_i) begin
            slot1         <= '0;
            slot1_ready_o <= 1'b0;
        end else begin
            slot1         <= next_slot1;
            slot1_ready_o <= next_slot1.ready;
        end
    end

    // Error counters; counting halts while bus-off
    always_comb begin
        next_tx = tx_cnt;
        next_rx = rx_cnt;
        if (can_soft_reset_i) begin
            next_tx = `CIE_RESET_COUNT;
            next_rx = `CIE_RESET_BYTE;
        end else if (wr_tx_ok) begin
            next_tx = {1'b0, sfr_wdata_i};
            next_rx = sfr_wdata_i;
        end else if (!bus_off_o) begin
            if (engine_evt_i.tx_error) begin
                if (tx_cnt > `CIE_BUSOFF_LIMIT - `CIE_TX_ERR_STEP) begin
                    next_tx = `CIE_BUSOFF_LIMIT + `CIE_COUNT_ONE;
                end else begin
                    next_tx = tx_cnt + `CIE_TX_ERR_STEP;
                end
            end else if (engine_evt_i.tx_ok && tx_cnt != 9'h000) begin
                next_tx = tx_cnt - `CIE_COUNT_ONE;
            end
            if (engine_evt_i.rx_error && rx_cnt != 8'hFF) begin
                next_rx = rx_cnt + 8'h01;
            end else if (engine_evt_i.rx_ok && rx_cnt != 8'h00) begin
                next_rx = rx_cnt - 8'h01;
            end
        end
    end

    // Limit compares the fresh counts so a zero write clears it at once
    assign limit = error_limit_select_i ? `CIE_PASSIVE_LIMIT
                                        : `CIE_WARN_LIMIT;
    assign next_limit = (next_tx >= limit) || ({1'b0, next_rx} >= limit);

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            tx_cnt             <= `CIE_RESET_COUNT;
            rx_cnt             <= `CIE_RESET_BYTE;
            error_limit_flag_o <= 1'b0;
            bus_off_o          <= 1'b0;
        end else begin
            tx_cnt             <= next_tx;
            rx_cnt             <= next_rx;
            error_limit_flag_o <= next_limit;
            bus_off_o          <= (next_tx > `CIE_BUSOFF_LIMIT);
        end
    end

    // Fault state from the transmit count
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            fault_state_o <= CIE_ERR_ACTIVE;
        end else if (next_tx > `CIE_BUSOFF_LIMIT) begin
            fault_state_o <= CIE_BUS_OFF;
        end else if (next_tx >= `CIE_PASSIVE_LIMIT) begin
            fault_state_o <= CIE_ERR_PASSIVE;
        end else if (next_tx >= `CIE_WARN_LIMIT) begin
            fault_state_o <= CIE_ERR_WARNING;
        end else begin
            fault_state_o <= CIE_ERR_ACTIVE;
        end
    end

    // Read data registered; unmapped addresses answer zero
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            sfr_rdata_o <= `CIE_RESET_BYTE;
        end else if (sfr_rd_i) begin
            case (sfr_addr_i)
                `CIE_ADDR_SOURCE:     sfr_rdata_o <= irq_source_code_o;
                `CIE_ADDR_TX_ERR:     sfr_rdata_o <= tx_cnt[8] ? 8'hFF
                                                            : tx_cnt[7:0];
                `CIE_ADDR_RX_ERR:     sfr_rdata_o <= rx_cnt;
                `CIE_ADDR_IRQ_ENABLE: sfr_rdata_o <= irq_enable;
                `CIE_ADDR_SLOT1_CTRL: sfr_rdata_o <= {slot1, 4'h0};
                default:              sfr_rdata_o <= `CIE_RESET_BYTE;
            endcase
        end
    end

    // Checks
    property p_code_after_reset;
        @(posedge sys_clk_i) disable iff (reset_i)
        $fell(reset_i) |-> irq_source_code_o == 8'h00;
    endproperty
    a_code_after_reset: assert property (p_code_after_reset)
        else $error("indicator not zero after reset");

    property p_code_hold;
        @(posedge sys_clk_i) disable iff (reset_i)
        (irq_source_code_o != 8'h00
            && cie_live(irq_source_code_o, status_pend, all_flags))
        |=> irq_source_code_o == $past(irq_source_code_o);
    endproperty
    a_code_hold: assert property (p_code_hold)
        else $error("indicator changed while source still active");

    property p_code_priority;
        @(posedge sys_clk_i) disable iff (reset_i)
        (irq_source_code_o == 8'h00 && status_pend)
        |=> irq_source_code_o == 8'h01;
    endproperty
    a_code_priority: assert property (p_code_priority)
        else $error("idle indicator did not load top source");

    property p_irq_level;
        @(posedge sys_clk_i) disable iff (reset_i)
        can_irq_o == (irq_source_code_o != 8'h00);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("request does not follow indicator");

    property p_status_remove;
        @(posedge sys_clk_i) disable iff (reset_i)
        (rd_status && irq_source_code_o == 8'h01
            && !engine_evt_i.status_change && !engine_evt_i.error_change)
        |=> ##1 irq_source_code_o != 8'h01;
    endproperty
    a_status_remove: assert property (p_status_remove)
        else $error("status source not removed by status read");

    property p_write_ignored;
        @(posedge sys_clk_i) disable iff (reset_i)
        (wr_tx && (!soft_init_mode_i || bus_off_o) && !can_soft_reset_i
            && engine_evt_i[7:4] == 4'h0)
        |=> tx_cnt == $past(tx_cnt) && rx_cnt == $past(rx_cnt);
    endproperty
    a_write_ignored: assert property (p_write_ignored)
        else $error("counter write taken outside init mode");

    property p_write_both;
        @(posedge sys_clk_i) disable iff (reset_i)
        (wr_tx_ok && !can_soft_reset_i)
        |=> tx_cnt == {1'b0, $past(sfr_wdata_i)}
            && rx_cnt == $past(sfr_wdata_i);
    endproperty
    a_write_both: assert property (p_write_both)
        else $error("counter write did not load both counters");

    property p_write_zero;
        @(posedge sys_clk_i) disable iff (reset_i)
        (wr_tx_ok && sfr_wdata_i == 8'h00) |=> !error_limit_flag_o;
    endproperty
    a_write_zero: assert property (p_write_zero)
        else $error("zero write left limit flag set");

    property p_soft_reset;
        @(posedge sys_clk_i) disable iff (reset_i)
        can_soft_reset_i |=> tx_cnt == 9'h000 && rx_cnt == 8'h00
                             && !slot1_ready_o && !bus_off_o;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("soft reset did not clear counters and ready");

    property p_bus_off;
        @(posedge sys_clk_i) disable iff (reset_i)
        bus_off_o == (tx_cnt > 9'h0FF)
        && ((fault_state_o == CIE_ERR_PASSIVE)
            == (tx_cnt >= 9'h080 && tx_cnt <= 9'h0FF));
    endproperty
    a_bus_off: assert property (p_bus_off)
        else $error("fault state disagrees with transmit count");

    property p_global_mask;
        @(posedge sys_clk_i) disable iff (reset_i)
        !irq_enable[7] |=> !can_irq_gated_o;
    endproperty
    a_global_mask: assert property (p_global_mask)
        else $error("request passed with global enable clear");

    property p_slot_skip;
        @(posedge sys_clk_i) disable iff (reset_i)
        (!slot1.ready && !slot1.irq_flag
            && !(sfr_wr_i && sfr_addr_i == 8'hAB)) |=> !slot1.irq_flag;
    endproperty
    a_slot_skip: assert property (p_slot_skip)
        else $error("unready slot raised its flag");

    property p_limit;
        @(posedge sys_clk_i) disable iff (reset_i)
        !$past(error_limit_select_i)
        |-> error_limit_flag_o == (tx_cnt >= 9'h060 || rx_cnt >= 8'h60);
    endproperty
    a_limit: assert property (p_limit)
        else $error("limit flag disagrees with counts at 96");

endmodule

// >>> cie_cpu_model.sv
`timescale 1ns/1ps
module cie_cpu_model
(
    // Clock
    input  wire logic       sys_clk_i,
    // Special function register bus
    output logic      [7:0] sfr_addr_o,
    output logic            sfr_wr_o,
    output logic            sfr_rd_o,
    output logic      [7:0] sfr_wdata_o,
    input  wire logic [7:0] sfr_rdata_i,
    // Interrupt requests from the block
    input  wire logic       can_irq_i,
    input  wire logic       powerfail_irq_i,
    output logic            irq_taken_o
);

    // Bus idles with both strobes low
    initial begin
        sfr_addr_o  = 8'h00;
        sfr_wdata_o = 8'h00;
        sfr_wr_o    = 1'b0;
        sfr_rd_o    = 1'b0;
    end

    // Core samples its request lines on every rising edge
    always_ff @(posedge sys_clk_i) begin
        irq_taken_o <= can_irq_i | powerfail_irq_i;
    end

    // One access: strobe for one edge, then take the answer
    task automatic access(input  logic       wr,
                          input  logic [7:0] addr,
                          input  logic [7:0] data,
                          output logic [7:0] rdat);
        @(negedge sys_clk_i);
        sfr_addr_o  = addr;
        sfr_wdata_o = data;
        sfr_wr_o    = wr;
        sfr_rd_o    = ~wr;
        @(negedge sys_clk_i);
        sfr_wr_o    = 1'b0;
        sfr_rd_o    = 1'b0;
        rdat        = sfr_rdata_i;
        // Released lines show no stale copy of the last access
        sfr_addr_o  = ~addr;
        sfr_wdata_o = ~data;
    endtask

endmodule

// >>> can_interrupt_error_status_tb.sv
`timescale 1ns/1ps
module can_interrupt_error_status_tb;
    import cie_pkg::*;

    // Design connections
    logic                sys_clk, reset, sfr_wr, sfr_rd, soft_rst, init;
    logic                sie, pfe, pfr, ready, irq, gated, pfo, lim, boff;
    logic                eie, sel;
    logic [7:0]          sfr_addr, sfr_wdata, sfr_rdata, code;
    logic [15:2]         flags;
    cie_engine_evt_type  evt;
    cie_fault_state_type fs;
    // Bench state
    int                  error_cnt, n_compared, seed, n, i;
    logic [7:0]          v, d;
    logic [7:0]          lvls [7];

    cie_core cie_core_i (
        .sys_clk_i(sys_clk), .reset_i(reset), .sfr_addr_i(sfr_addr),
        .sfr_wr_i(sfr_wr), .sfr_rd_i(sfr_rd), .sfr_wdata_i(sfr_wdata),
        .sfr_rdata_o(sfr_rdata), .can_soft_reset_i(soft_rst),
        .soft_init_mode_i(init), .error_limit_select_i(sel),
        .error_irq_enable_i(eie), .status_irq_enable_i(sie),
        .powerfail_irq_enable_i(pfe), .powerfail_req_i(pfr),
        .engine_evt_i(evt), .slot_irq_flag_i(flags),
        .slot1_ready_o(ready), .irq_source_code_o(code), .can_irq_o(irq),
        .can_irq_gated_o(gated), .powerfail_irq_o(pfo),
        .error_limit_flag_o(lim), .bus_off_o(boff), .fault_state_o(fs));

    cie_cpu_model cie_cpu_model_i (
        .sys_clk_i(sys_clk), .sfr_addr_o(sfr_addr), .sfr_wr_o(sfr_wr),
        .sfr_rd_o(sfr_rd), .sfr_wdata_o(sfr_wdata), .sfr_rdata_i(sfr_rdata),
        .can_irq_i(gated), .powerfail_irq_i(pfo), .irq_taken_o());

    // 125 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (error_cnt == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        logic [7:0] dummy;
        cie_cpu_model_i.access(1'b1, a, dat, dummy);
    endtask

    task automatic rd(input logic [7:0] a);
        cie_cpu_model_i.access(1'b0, a, 8'h00, v);
    endtask

    // One-cycle engine event, launched off the falling edge
    task automatic pulse(input cie_engine_evt_type e);
        @(negedge sys_clk);
        evt = e;
        @(negedge sys_clk);
        evt = '0;
    endtask

    // Expected one-hot state from a transmit count
    function automatic logic [7:0] fs_exp(input int c);
        if (c < 96) return 8'h01;
        if (c < 128) return 8'h02;
        if (c <= 255) return 8'h04;
        return 8'h08;
    endfunction

    // Hang guard, far beyond the few hundred cycles of the run
    initial begin
        #(30000 * 8);
        error_cnt++;
        finish_test();
    end

    initial begin
        {reset, soft_rst, init, sie, pfe, pfr, eie, sel} = 8'h80;
        evt = '0;
        flags = '0;
        error_cnt = 0;
        n_compared = 0;
        seed = 9;
        cyc(10);
        reset = 1'b0;
        cyc(1);
        // Reset values of every mapped register
        foreach (lvls[k]) lvls[k] = 8'h00;
        for (i = 0; i < 5; i++) begin
            rd(i == 0 ? 8'hA5 : (i == 4 ? 8'hAB : 8'hA5 + i[7:0]));
            check(v, 8'h00);
        end
        check({4'h0, fs}, 8'h01);
        // Counter write refused outside init mode
        wr(8'hA6, 8'h55);
        rd(8'hA6);
        check(v, 8'h00);
        // Init mode lets the counters be written
        init = 1'b1;
        // Limit at 128 when selected, back to 96 when not
        sel = 1'b1;
        wr(8'hA6, 8'h7F);
        check({7'h00, lim}, 8'h00);
        sel = 1'b0;
        cyc(1);
        check({7'h00, lim}, 8'h01);
        lvls = '{8'h60, 8'h5F, 8'h7F, 8'h80, 8'hFF, 8'h00, 8'h00};
        lvls[5] = 8'($random(seed));
        for (i = 0; i < 7; i++) begin
            d = lvls[i];
            wr(8'hA6, d);
            rd(8'hA6);
            check(v, d);
            rd(8'hA7);
            check(v, d);
            check({4'h0, fs}, fs_exp(d));
            check({7'h00, lim}, {7'h00, d >= 8'h60});
        end
        // Receive errors count up by one
        pulse('{rx_error: 1'b1, default: 1'b0});
        cyc(1);
        rd(8'hA7);
        check(v, 8'h01);
        // Push the transmit count past 255
        wr(8'hA6, 8'hF8);
        pulse('{tx_error: 1'b1, default: 1'b0});
        cyc(1);
        check({7'h00, boff}, 8'h01);
        check({4'h0, fs}, 8'h08);
        wr(8'hA6, 8'h10);
        rd(8'hA7);
        check(v, 8'hF8);
        // Soft reset clears both counters and bus off
        soft_rst = 1'b1;
        cyc(1);
        soft_rst = 1'b0;
        rd(8'hA6);
        check(v, 8'h00);
        rd(8'hA7);
        check(v, 8'h00);
        check({7'h00, boff}, 8'h00);
        init = 1'b0;
        // Status change, then a later higher source must wait
        sie = 1'b1;
        pulse('{status_change: 1'b1, default: 1'b0});
        flags[3] = 1'b1;
        cyc(3);
        check(code, 8'h01);
        check({7'h00, irq}, 8'h01);
        flags[15] = 1'b1;
        cyc(3);
        check(code, 8'h01);
        rd(8'hA4);
        cyc(3);
        check(code, 8'h02);
        flags[15] = 1'b0;
        cyc(3);
        check(code, 8'h05);
        flags[15] = 1'b1;
        cyc(3);
        check(code, 8'h05);
        flags = '0;
        cyc(3);
        check(code, 8'h00);
        check({7'h00, irq}, 8'h00);
        // Status change needs its own enable; error change uses the other
        sie = 1'b0;
        pulse('{status_change: 1'b1, default: 1'b0});
        cyc(3);
        check(code, 8'h00);
        eie = 1'b1;
        pulse('{error_change: 1'b1, default: 1'b0});
        cyc(3);
        check(code, 8'h01);
        rd(8'hA4);
        cyc(3);
        check(code, 8'h00);
        // Slots 2 to 14 alone, and each paired with slot 15
        for (n = 2; n < 15; n++) begin
            flags[n] = 1'b1;
            cyc(3);
            check(code, 8'(n + 2));
            flags = '0;
            cyc(3);
            flags[n] = 1'b1;
            flags[15] = 1'b1;
            cyc(3);
            check(code, 8'h02);
            flags = '0;
            cyc(3);
        end
        // Slot 1 flag through its control register
        wr(8'hAB, 8'hA0);
        pulse('{slot1_rx_done: 1'b1, default: 1'b0});
        cyc(3);
        check(code, 8'h03);
        rd(8'hAB);
        check(v, 8'hB0);
        wr(8'hAB, 8'hA0);
        cyc(3);
        check(code, 8'h00);
        // Unready slot ignored, other slots unaffected
        wr(8'hAB, 8'h20);
        flags[2] = 1'b1;
        pulse('{slot1_rx_done: 1'b1, default: 1'b0});
        cyc(3);
        check({7'h00, ready}, 8'h00);
        check(code, 8'h04);
        // Global enable gates the request, power-fail passes
        check({7'h00, gated}, 8'h00);
        wr(8'hA8, 8'h80);
        cyc(2);
        check({7'h00, gated}, 8'h01);
        rd(8'hA8);
        check(v, 8'h80);
        {pfe, pfr} = 2'b11;
        wr(8'hA8, 8'h00);
        cyc(2);
        check({6'h00, gated, pfo}, 8'h01);
        flags = '0;
        // Soft reset drops the ready bit
        wr(8'hAB, 8'h80);
        cyc(1);
        check({7'h00, ready}, 8'h01);
        soft_rst = 1'b1;
        cyc(1);
        soft_rst = 1'b0;
        cyc(1);
        check({7'h00, ready}, 8'h00);
        // Hardware reset in mid-run clears indicator and receive counter
        {init, flags[6]} = 2'b11;
        wr(8'hA6, 8'h44);
        check(code, 8'h08);
        rd(8'hA7);
        check(v, 8'h44);
        reset = 1'b1;
        cyc(2);
        {reset, flags} = '0;
        cyc(1);
        check(code, 8'h00);
        rd(8'hA7);
        check(v, 8'h00);
        finish_test();
    end

endmodule
